// file: common/rbcfp_params.svh
// constants of the reference-buffer control field parser
// assumes inclusion by the design file only
`ifndef RBCFP_PARAMS_SVH
`define RBCFP_PARAMS_SVH
// register byte offsets
`define RBCFP_CTRL_OFF      8'h00
`define RBCFP_PICSIZE_OFF   8'h04
`define RBCFP_GEOM_OFF      8'h08
`define RBCFP_BUFSTAT_OFF   8'h0C
`define RBCFP_SPSIZE_OFF    8'h10
`define RBCFP_LASTOP_OFF    8'h14
`define RBCFP_LIMIT_OFF     8'h18
// field positions
`define RBCFP_CTRL_MRF_BIT  16
`define RBCFP_LIMIT_ERR_BIT 24
// reset values
`define RBCFP_CTRL_RST      32'h0000_0000
`define RBCFP_PICSIZE_RST   32'h0090_00B0
`define RBCFP_MAXLT_RST     16'h0000
// arithmetic constants
`define RBCFP_PN_MODULO     11'h400
`define RBCFP_SAMPLE_UNIT   5'h10
`define RBCFP_UNIT_ROUND    16'h000F
`define RBCFP_FIELD_LAST    3'h6
`define RBCFP_STUFF_RUN     4'h8
`define RBCFP_LT_SLOTS      16
`endif

// file: common/rbcfp_pkg.sv
// types of the reference-buffer control field parser
// assumes nothing beyond a SystemVerilog compiler
package rbcfp_pkg;
	typedef enum logic [3:0] {
		ST_CMD   = 4'h0, ST_DPN = 4'h1, ST_LONG_TERM_INDEX = 4'h2, ST_MAXLT = 4'h3,
		ST_SPW   = 4'h4, ST_SPH = 4'h5, ST_CAP  = 4'h6, ST_RST   = 4'h7,
		ST_MAP   = 4'h8
	} rbcfp_state_type;
	typedef enum logic [2:0] {
		OP_END    = 3'h0, OP_ST_UNUSED = 3'h1, OP_LT_UNUSED = 3'h2,
		OP_ASSIGN = 3'h3, OP_ST_SUB    = 3'h4, OP_LT_SUB    = 3'h5,
		OP_MAXLT  = 3'h6, OP_GEOM      = 3'h7
	} rbcfp_op_type;
	typedef enum logic [2:0] {
		ACT_MARK_ST  = 3'h0, ACT_MARK_CUR = 3'h1, ACT_MARK_LT  = 3'h2,
		ACT_ASSIGN   = 3'h3, ACT_SUB_ST   = 3'h4, ACT_SUB_LT   = 3'h5,
		ACT_LT_ABOVE = 3'h6, ACT_RESET    = 3'h7
	} rbcfp_act_type;
	typedef struct packed {
		logic        valid;
		logic        is_value;
		logic        bit_data;
		logic [15:0] value;
	} rbcfp_sym_type;
	typedef struct packed {
		logic          valid;
		rbcfp_act_type kind;
		logic [9:0]    pic;
		logic [15:0]   index;
		logic [15:0]   subpic;
	} rbcfp_action_type;
	typedef struct packed {
		logic valid;
		logic skipped;
		logic inter;
		logic mv_zero;
		logic ref_zero;
		logic no_coeff;
		logic extended_syntax;
	} rbcfp_mb_type;
endpackage

// file: hw/rbcfp_parser.sv
// reference-buffer control field parser: command list, fields, marking
// assumes symbols from same-clock logic (bits raw, variable-length fields
// already decoded) and an AHB-Lite master for the registers
//
// Summary of operation
// - target number is current minus difference, plus 1024 when negative.
// - short-term unused with difference zero marks the current picture unused.
// - index follows difference for assignment, else directly follows command.
// - bitmap length is one bit per sub-picture from latest geometry.
// - bitmap follows difference for short-term, index for long-term target.
// - bitmap bits map raster order from top-left; ones mark areas unused.
// - a stuffing one follows eight zero bitmap bits and is skipped.
// - max long-term index plus one is zero until a value arrives.
// - new max value marks long-term pictures above value minus one unused.
// - width field is 7 bits after command; width 16 times field plus one.
// - sub-pictures across is ceil(ceil(width/16)/(field plus one)).
// - height field is 7 bits after width; height 16 times field, 1..72.
// - sub-pictures down is ceil(ceil(height/16)/height field).
// - capacity follows height; value is table index plus one.
// - whole-picture short-term limit is capacity minus long-terms in use.
// - reset flag follows capacity; one marks all buffered pictures unused.
// - skipped macroblock is inter, zero vector, reference zero, no coeffs.
// - extended macroblock syntax only when multiple-reference flag is one.
// - codes 1 end, 011 short-term unused, 0100 long-term unused.
// - codes 0101 assign, 00100 short-term and 00101 long-term removal.
// - codes 00110 max index and 00111 geometry with its four fields.
`timescale 1ns/1ps
`include "rbcfp_params.svh"

module rbcfp_parser (
	input  wire logic                    mclk,
	input  wire logic                    arst_n,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire rbcfp_pkg::rbcfp_sym_type sym_in,
	output logic                         want_value,
	output rbcfp_pkg::rbcfp_action_type  action_out,
	output logic                         list_done,
	input  wire logic                    mb_in_valid,
	input  wire logic                    mb_skip_bit,
	output rbcfp_pkg::rbcfp_mb_type      mb_out,
	output logic [15:0]                  short_term_limit
);
	rbcfp_pkg::rbcfp_state_type  state_reg;
	rbcfp_pkg::rbcfp_state_type  state_next;
	rbcfp_pkg::rbcfp_op_type     op_reg;
	rbcfp_pkg::rbcfp_op_type     dec_op;
	logic                        dec_hit;
	logic                        dec_bad;
	logic [4:0]                  code_reg;
	logic [2:0]                  code_len_reg;
	logic [4:0]                  cmd_c;
	logic [2:0]                  cmd_len;
	logic [6:0]                  fld_reg;
	logic [2:0]                  fld_cnt_reg;
	logic [9:0]                  target_reg;
	logic [9:0]                  target;
	logic [10:0]                 pn_diff;
	logic [10:0]                 pn_wrap;
	logic [6:0]                  sp_w_reg;
	logic [6:0]                  sp_h_reg;
	logic [15:0]                 cap_reg;
	logic [15:0]                 max_lt_reg;
	logic [15:0]                 map_idx_reg;
	logic [3:0]                  zrun_reg;
	logic [3:0]                  zrun_new;
	logic                        map_stuff;
	logic [15:0]                 total_reg;
	logic [16:0]                 w_units;
	logic [16:0]                 h_units;
	logic [16:0]                 across;
	logic [16:0]                 down;
	logic [16:0]                 h_div;
	logic [33:0]                 total_full;
	logic                        lt_used_reg [0:`RBCFP_LT_SLOTS-1];
	logic [4:0]                  lt_count;
	logic [9:0]                  pnc_reg;
	logic                        mrf_reg;
	logic [15:0]                 pic_w_reg;
	logic [15:0]                 pic_h_reg;
	logic                        err_reg;
	logic                        bit_ok;
	logic                        val_ok;
	logic                        bit_state;
	logic                        val_state;
	logic                        ahb_take;
	logic                        wr_pend_reg;
	logic [7:0]                  wr_addr_reg;
	logic [31:0]                 rd_mux;
	logic                        err_clr;
	rbcfp_pkg::rbcfp_action_type act_reg;
	rbcfp_pkg::rbcfp_mb_type     mb_reg;
	logic                        want_value_reg;
	logic                        list_done_reg;
	logic [15:0]                 st_limit_reg;
	logic [31:0]                 hrdata_reg;
	logic                        hreadyout_reg;
	logic                        hresp_reg;

	// outputs straight from flops
	assign hreadyout        = hreadyout_reg;
	assign hresp            = hresp_reg;
	assign hrdata           = hrdata_reg;
	assign want_value       = want_value_reg;
	assign action_out       = act_reg;
	assign list_done        = list_done_reg;
	assign mb_out           = mb_reg;
	assign short_term_limit = st_limit_reg;

	// a symbol of the wrong kind for the state is dropped and flagged
	assign bit_state = (state_reg == rbcfp_pkg::ST_CMD) ||
		(state_reg == rbcfp_pkg::ST_SPW) || (state_reg == rbcfp_pkg::ST_SPH) ||
		(state_reg == rbcfp_pkg::ST_RST) || (state_reg == rbcfp_pkg::ST_MAP);
	assign val_state = !bit_state;
	assign bit_ok    = sym_in.valid && !sym_in.is_value && bit_state;
	assign val_ok    = sym_in.valid && sym_in.is_value && val_state;

	// target picture number, wrapped into the 1024 number space
	assign pn_diff = {1'b0, pnc_reg} - {1'b0, sym_in.value[9:0]};
	assign pn_wrap = pn_diff + `RBCFP_PN_MODULO;
	assign target  = pn_diff[10] ? pn_wrap[9:0] : pn_diff[9:0];

	// bitmap stuffing: the bit after eight data zeros is skipped
	assign map_stuff = (zrun_reg == `RBCFP_STUFF_RUN);
	assign zrun_new  = sym_in.bit_data ? 4'h0 : zrun_reg + 4'h1;

	// command code prefix decode, one bit per symbol
	always_comb begin
		cmd_c   = {code_reg[3:0], sym_in.bit_data};
		cmd_len = code_len_reg + 3'h1;
		dec_op  = rbcfp_pkg::OP_END;
		dec_hit = 1'b0;
		dec_bad = 1'b0;
		case (cmd_len)
			3'h1: begin
				dec_hit = cmd_c[0];
			end
			3'h3: begin
				if (cmd_c[2:0] == 3'h3) begin
					dec_hit = 1'b1;
					dec_op  = rbcfp_pkg::OP_ST_UNUSED;
				end else if (cmd_c[2:0] == 3'h0) begin
					dec_bad = 1'b1;
				end
			end
			3'h4: begin
				if (cmd_c[3:1] == 3'h2) begin
					dec_hit = 1'b1;
					dec_op  = cmd_c[0] ? rbcfp_pkg::OP_ASSIGN
						: rbcfp_pkg::OP_LT_UNUSED;
				end
			end
			3'h5: begin
				dec_hit = 1'b1;
				dec_op  = rbcfp_pkg::rbcfp_op_type'({1'b1, cmd_c[1:0]});
			end
			default: begin
				dec_hit = 1'b0;
			end
		endcase
	end

	// next parser state; field order follows the command
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			rbcfp_pkg::ST_CMD: begin
				if (bit_ok && dec_hit) begin
					case (dec_op)
						rbcfp_pkg::OP_ST_UNUSED,
						rbcfp_pkg::OP_ASSIGN,
						rbcfp_pkg::OP_ST_SUB:    state_next = rbcfp_pkg::ST_DPN;
						rbcfp_pkg::OP_LT_UNUSED,
						rbcfp_pkg::OP_LT_SUB:    state_next = rbcfp_pkg::ST_LONG_TERM_INDEX;
						rbcfp_pkg::OP_MAXLT:     state_next = rbcfp_pkg::ST_MAXLT;
						rbcfp_pkg::OP_GEOM:      state_next = rbcfp_pkg::ST_SPW;
						default:                 state_next = rbcfp_pkg::ST_CMD;
					endcase
				end
			end
			rbcfp_pkg::ST_DPN: begin
				if (val_ok) begin
					if (op_reg == rbcfp_pkg::OP_ST_SUB) begin
						state_next = rbcfp_pkg::ST_MAP;
					end else if (op_reg == rbcfp_pkg::OP_ASSIGN) begin
						state_next = rbcfp_pkg::ST_LONG_TERM_INDEX;
					end else begin
						state_next = rbcfp_pkg::ST_CMD;
					end
				end
			end
			rbcfp_pkg::ST_LONG_TERM_INDEX: begin
				if (val_ok) begin
					state_next = (op_reg == rbcfp_pkg::OP_LT_SUB) ?
						rbcfp_pkg::ST_MAP : rbcfp_pkg::ST_CMD;
				end
			end
			rbcfp_pkg::ST_MAP: begin
				if (bit_ok) begin
					if (map_stuff) begin
						if (map_idx_reg >= total_reg) begin
							state_next = rbcfp_pkg::ST_CMD;
						end
					end else if ((map_idx_reg + 16'h0001 >= total_reg) &&
						(zrun_new != `RBCFP_STUFF_RUN)) begin
						state_next = rbcfp_pkg::ST_CMD;
					end
				end
			end
			rbcfp_pkg::ST_MAXLT: begin
				if (val_ok) begin
					state_next = rbcfp_pkg::ST_CMD;
				end
			end
			rbcfp_pkg::ST_SPW: begin
				if (bit_ok && fld_cnt_reg == `RBCFP_FIELD_LAST) begin
					state_next = rbcfp_pkg::ST_SPH;
				end
			end
			rbcfp_pkg::ST_SPH: begin
				if (bit_ok && fld_cnt_reg == `RBCFP_FIELD_LAST) begin
					state_next = rbcfp_pkg::ST_CAP;
				end
			end
			rbcfp_pkg::ST_CAP: begin
				if (val_ok) begin
					state_next = rbcfp_pkg::ST_RST;
				end
			end
			rbcfp_pkg::ST_RST: begin
				if (bit_ok) begin
					state_next = rbcfp_pkg::ST_CMD;
				end
			end
			default: begin
				state_next = rbcfp_pkg::ST_CMD;
			end
		endcase
	end

	// parser state and the fields it collects
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg      <= rbcfp_pkg::ST_CMD;
			op_reg         <= rbcfp_pkg::OP_END;
			code_reg       <= 5'h00;
			code_len_reg   <= 3'h0;
			fld_reg        <= 7'h00;
			fld_cnt_reg    <= 3'h0;
			target_reg     <= 10'h000;
			sp_w_reg       <= 7'h00;
			sp_h_reg       <= 7'h01;
			cap_reg        <= 16'h0000;
			max_lt_reg     <= `RBCFP_MAXLT_RST;
			map_idx_reg    <= 16'h0000;
			zrun_reg       <= 4'h0;
			want_value_reg <= 1'b0;
			list_done_reg  <= 1'b0;
		end else begin
			state_reg      <= state_next;
			want_value_reg <= (state_next == rbcfp_pkg::ST_DPN) ||
				(state_next == rbcfp_pkg::ST_LONG_TERM_INDEX) ||
				(state_next == rbcfp_pkg::ST_MAXLT) ||
				(state_next == rbcfp_pkg::ST_CAP);
			list_done_reg  <= bit_ok && (state_reg == rbcfp_pkg::ST_CMD) &&
				dec_hit && (dec_op == rbcfp_pkg::OP_END);
			case (state_reg)
				rbcfp_pkg::ST_CMD: begin
					if (bit_ok && (dec_hit || dec_bad)) begin
						code_reg     <= 5'h00;
						code_len_reg <= 3'h0;
						op_reg       <= dec_op;
					end else if (bit_ok) begin
						code_reg     <= cmd_c;
						code_len_reg <= cmd_len;
					end
					fld_cnt_reg <= 3'h0;
					map_idx_reg <= 16'h0000;
					zrun_reg    <= 4'h0;
				end
				rbcfp_pkg::ST_DPN: begin
					if (val_ok) begin
						target_reg <= target;
					end
				end
				rbcfp_pkg::ST_MAP: begin
					if (bit_ok && map_stuff) begin
						zrun_reg <= 4'h0;
					end else if (bit_ok) begin
						zrun_reg    <= zrun_new;
						map_idx_reg <= map_idx_reg + 16'h0001;
					end
				end
				rbcfp_pkg::ST_MAXLT: begin
					if (val_ok) begin
						max_lt_reg <= sym_in.value;
					end
				end
				rbcfp_pkg::ST_SPW, rbcfp_pkg::ST_SPH: begin
					if (bit_ok) begin
						fld_reg     <= {fld_reg[5:0], sym_in.bit_data};
						fld_cnt_reg <= fld_cnt_reg + 3'h1;
						if (fld_cnt_reg == `RBCFP_FIELD_LAST) begin
							fld_cnt_reg <= 3'h0;
							if (state_reg == rbcfp_pkg::ST_SPW) begin
								sp_w_reg <= {fld_reg[5:0], sym_in.bit_data};
							end else begin
								sp_h_reg <= {fld_reg[5:0], sym_in.bit_data};
							end
						end
					end
				end
				rbcfp_pkg::ST_CAP: begin
					if (val_ok) begin
						cap_reg <= sym_in.value + 16'h0001;
					end
				end
				default: begin
					fld_cnt_reg <= fld_cnt_reg;
				end
			endcase
		end
	end

	// marking actions, one pulse per decoded effect
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			act_reg <= '0;
		end else begin
			act_reg.valid <= 1'b0;
			if (val_ok && state_reg == rbcfp_pkg::ST_DPN &&
				op_reg == rbcfp_pkg::OP_ST_UNUSED) begin
				act_reg.valid <= 1'b1;
				act_reg.pic   <= target;
				act_reg.kind  <= (sym_in.value == 16'h0000) ?
					rbcfp_pkg::ACT_MARK_CUR : rbcfp_pkg::ACT_MARK_ST;
			end else if (val_ok && state_reg == rbcfp_pkg::ST_LONG_TERM_INDEX &&
				op_reg != rbcfp_pkg::OP_LT_SUB) begin
				act_reg.valid <= 1'b1;
				act_reg.pic   <= target_reg;
				act_reg.index <= sym_in.value;
				act_reg.kind  <= (op_reg == rbcfp_pkg::OP_ASSIGN) ?
					rbcfp_pkg::ACT_ASSIGN : rbcfp_pkg::ACT_MARK_LT;
			end else if (val_ok && state_reg == rbcfp_pkg::ST_LONG_TERM_INDEX) begin
				act_reg.index <= sym_in.value;
			end else if (bit_ok && state_reg == rbcfp_pkg::ST_MAP &&
				!map_stuff && sym_in.bit_data) begin
				act_reg.valid  <= 1'b1;
				act_reg.pic    <= target_reg;
				act_reg.subpic <= map_idx_reg;
				act_reg.kind   <= (op_reg == rbcfp_pkg::OP_LT_SUB) ?
					rbcfp_pkg::ACT_SUB_LT : rbcfp_pkg::ACT_SUB_ST;
			end else if (val_ok && state_reg == rbcfp_pkg::ST_MAXLT) begin
				act_reg.valid <= 1'b1;
				act_reg.index <= sym_in.value;
				act_reg.kind  <= rbcfp_pkg::ACT_LT_ABOVE;
			end else if (bit_ok && state_reg == rbcfp_pkg::ST_RST &&
				sym_in.bit_data) begin
				act_reg.valid <= 1'b1;
				act_reg.kind  <= rbcfp_pkg::ACT_RESET;
			end
		end
	end

	// sub-picture grid; a zero height field is illegal and taken as one
	always_comb begin
		w_units    = {1'b0, pic_w_reg + `RBCFP_UNIT_ROUND} >> 4;
		h_units    = {1'b0, pic_h_reg + `RBCFP_UNIT_ROUND} >> 4;
		across     = (w_units + {10'h000, sp_w_reg}) /
			({10'h000, sp_w_reg} + 17'h00001);
		h_div      = (sp_h_reg == 7'h00) ? 17'h00001 : {10'h000, sp_h_reg};
		down       = (h_units + h_div - 17'h00001) / h_div;
		total_full = across * down;
	end

	// derived count held so later bitmaps are sized from it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			total_reg <= 16'h0000;
		end else begin
			total_reg <= total_full[15:0];
		end
	end

	// long-term slots in use, one flop per index
	genvar g;
	generate
		for (g = 0; g < `RBCFP_LT_SLOTS; g = g + 1) begin : g_lt
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					lt_used_reg[g] <= 1'b0;
				end else if (act_reg.valid) begin
					if (act_reg.kind == rbcfp_pkg::ACT_RESET) begin
						lt_used_reg[g] <= 1'b0;
					end else if (act_reg.kind == rbcfp_pkg::ACT_LT_ABOVE &&
						act_reg.index <= 16'(g)) begin
						lt_used_reg[g] <= 1'b0;
					end else if (act_reg.kind == rbcfp_pkg::ACT_MARK_LT &&
						act_reg.index == 16'(g)) begin
						lt_used_reg[g] <= 1'b0;
					end else if (act_reg.kind == rbcfp_pkg::ACT_ASSIGN &&
						act_reg.index == 16'(g)) begin
						lt_used_reg[g] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// count of long-term pictures still in use
	always_comb begin
		lt_count = 5'h00;
		for (int i = 0; i < `RBCFP_LT_SLOTS; i++) begin
			lt_count = lt_count + {4'h0, lt_used_reg[i]};
		end
	end

	// short-term limit only meaningful with whole-picture sub-pictures
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_limit_reg <= 16'h0000;
		end else if (total_reg == 16'h0001) begin
			st_limit_reg <= (cap_reg > {11'h000, lt_count}) ?
				cap_reg - {11'h000, lt_count} : 16'h0000;
		end else begin
			st_limit_reg <= cap_reg;
		end
	end

	// skipped macroblock interpretation and syntax choice
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mb_reg <= '0;
		end else begin
			mb_reg.valid           <= mb_in_valid;
			mb_reg.skipped         <= mb_skip_bit;
			mb_reg.inter           <= mb_skip_bit;
			mb_reg.mv_zero         <= mb_skip_bit;
			mb_reg.ref_zero        <= mb_skip_bit;
			mb_reg.no_coeff        <= mb_skip_bit;
			mb_reg.extended_syntax <= !mb_skip_bit && mrf_reg;
		end
	end

	// sticky protocol error; a new error wins over the software clear
	assign err_clr = wr_pend_reg && (wr_addr_reg == `RBCFP_LIMIT_OFF) &&
		hwdata[`RBCFP_LIMIT_ERR_BIT];
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			err_reg <= 1'b0;
		end else if ((bit_ok && state_reg == rbcfp_pkg::ST_CMD && dec_bad) ||
			(sym_in.valid && !bit_ok && !val_ok)) begin
			err_reg <= 1'b1;
		end else if (err_clr) begin
			err_reg <= 1'b0;
		end
	end

	// AHB-Lite address phase; zero wait, always OKAY
	assign ahb_take = hsel && hready && htrans[1];
	always_comb begin
		case (haddr[7:0])
			`RBCFP_CTRL_OFF:    rd_mux = {15'h0000, mrf_reg, 6'h00, pnc_reg};
			`RBCFP_PICSIZE_OFF: rd_mux = {pic_h_reg, pic_w_reg};
			`RBCFP_GEOM_OFF:    rd_mux = {total_reg, 1'b0, sp_h_reg,
				1'b0, sp_w_reg};
			`RBCFP_BUFSTAT_OFF: rd_mux = {max_lt_reg, cap_reg};
			`RBCFP_SPSIZE_OFF:  rd_mux = {5'h00, sp_h_reg, 4'h0,
				4'h0, {1'b0, sp_w_reg} + 8'h01, 4'h0};
			`RBCFP_LASTOP_OFF:  rd_mux = {4'h0, state_reg, 5'h00,
				op_reg, 6'h00, target_reg};
			`RBCFP_LIMIT_OFF:   rd_mux = {7'h00, err_reg, 3'h0, lt_count,
				st_limit_reg};
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// bus slave: capture address, register read data, hold status
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr_pend_reg   <= 1'b0;
			wr_addr_reg   <= 8'h00;
			hrdata_reg    <= 32'h0000_0000;
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
		end else begin
			wr_pend_reg   <= ahb_take && hwrite;
			wr_addr_reg   <= haddr[7:0];
			hreadyout_reg <= 1'b1;
			hresp_reg     <= 1'b0;
			if (ahb_take && !hwrite) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	// reset word split into its two sizes
	localparam logic [31:0] picsize_rst = `RBCFP_PICSIZE_RST;
	// writable control: current number, flag, picture size
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pnc_reg   <= 10'h000;
			mrf_reg   <= 1'b0;
			pic_w_reg <= picsize_rst[15:0];
			pic_h_reg <= picsize_rst[31:16];
		end else if (wr_pend_reg) begin
			if (wr_addr_reg == `RBCFP_CTRL_OFF) begin
				pnc_reg <= hwdata[9:0];
				mrf_reg <= hwdata[`RBCFP_CTRL_MRF_BIT];
			end else if (wr_addr_reg == `RBCFP_PICSIZE_OFF) begin
				pic_w_reg <= hwdata[15:0];
				pic_h_reg <= hwdata[31:16];
			end
		end
	end
endmodule

// file: testbench/rbcfp_encoder_model.sv
// encoder stand-in: feeds command codes, values and bitmaps
// assumes the parser takes one symbol per clock in the order sent
`timescale 1ns/1ps
module rbcfp_encoder_model (
	input	wire logic			mclk,
	output	rbcfp_pkg::rbcfp_sym_type	sym
);
	initial sym = '0;
	// one symbol per edge
	task automatic put(input logic v, input logic [15:0] d);
		@(posedge mclk);
		sym <= '{1'b1, v, d[0], d};
	endtask
	// payload inverted when idle so a stale symbol never looks current
	task automatic idle;
		@(posedge mclk);
		sym <= {1'b0, ~sym[17:0]};
	endtask
	task automatic val(input logic [15:0] d);
		put(1'b1, d);
	endtask
	task automatic bits(input logic [15:0] b, input int n);
		for (int i = n - 1; i >= 0; i--)
			put(1'b0, {15'h0, b[i]});
	endtask
	// a one follows eight zero data bits so no start code can form
	task automatic map(input logic [15:0] b, keep, input int n);
		int z;
		z = 0;
		b = b | keep;
		for (int i = n - 1; i >= 0; i--) begin
			put(1'b0, {15'h0, b[i]});
			z = b[i] ? 0 : z + 1;
			if (z == 8) begin
				put(1'b0, 16'h1);
				z = 0;
			end
		end
	endtask
	// difference wrapped into the picture-number space
	function automatic logic [15:0] diff(input int c, t);
		return 16'((c - t < 0) ? c - t + 1024 : c - t);
	endfunction
endmodule

// file: testbench/rbcfp_parser_chk.sv
// assertions on the parser's symbol and macroblock ports
// assumes binding onto rbcfp_parser; sees its ports only
`timescale 1ns/1ps
module rbcfp_parser_chk (
	input	wire logic				mclk,
	input	wire logic				arst_n,
	input	wire rbcfp_pkg::rbcfp_sym_type		sym_in,
	input	wire rbcfp_pkg::rbcfp_action_type	action_out,
	input	wire logic				list_done,
	input	wire logic				mb_in_valid,
	input	wire logic				mb_skip_bit,
	input	wire rbcfp_pkg::rbcfp_mb_type		mb_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// results come one cycle after the symbol that completes them
	property p_cause;
		action_out.valid || list_done |-> $past(sym_in.valid);
	endproperty
	a_cause: assert property (p_cause) else $error("result without symbol");
	property p_done;
		list_done |-> $past(!sym_in.is_value && sym_in.bit_data);
	endproperty
	a_done: assert property (p_done) else $error("end without one bit");
	// value-carried commands finish on a value, bitmaps on a bit
	property p_value;
		action_out.valid && (!action_out.kind[2] || action_out.kind == 3'h6)
			|-> $past(sym_in.is_value);
	endproperty
	a_value: assert property (p_value) else $error("action not on value");
	property p_bitmap;
		action_out.valid && action_out.kind[2:1] == 2'h2
			|-> $past(!sym_in.is_value && sym_in.valid);
	endproperty
	a_bitmap: assert property (p_bitmap) else $error("area not on bit");
	property p_reset;
		action_out.valid && action_out.kind == 3'h7
			|-> $past(!sym_in.is_value && sym_in.bit_data);
	endproperty
	a_reset: assert property (p_reset) else $error("reset not on one");
	// macroblock decision lands exactly one cycle later
	property p_mbv;
		mb_in_valid |=> mb_out.valid;
	endproperty
	a_mbv: assert property (p_mbv) else $error("macroblock result late");
	property p_skip;
		mb_in_valid && mb_skip_bit |=> mb_out.inter && mb_out.mv_zero
			&& mb_out.ref_zero && mb_out.no_coeff;
	endproperty
	a_skip: assert property (p_skip) else $error("skipped mb wrong");
	property p_ext;
		mb_in_valid && mb_skip_bit |=> !mb_out.extended_syntax;
	endproperty
	a_ext: assert property (p_ext) else $error("extended on skip");
endmodule

bind rbcfp_parser rbcfp_parser_chk u_chk (.mclk, .arst_n, .sym_in,
	.action_out, .list_done, .mb_in_valid, .mb_skip_bit, .mb_out);

// file: testbench/rbcfp_parser_tb.sv
// bench of the parser: registers, command fields, macroblocks
// assumes the encoder model feeds symbols; one slave on the bus
`timescale 1ns/1ps
module rbcfp_parser_tb;
	logic	mclk, arst_n, hsel, hwrite, hreadyout, hresp;
	logic	want_value, list_done, mb_in_valid, mb_skip_bit;
	logic [31:0]	haddr, hwdata, hrdata, rd;
	logic [15:0]	short_term_limit;
	logic [2:0]	hsize;
	logic [1:0]	htrans;
	rbcfp_pkg::rbcfp_sym_type	sym_in;
	rbcfp_pkg::rbcfp_action_type	action_out, last;
	rbcfp_pkg::rbcfp_mb_type	mb_out;
	int	fail_count = 0, samples_checked = 0, acts = 0, seen = 0, odd = 0, ends = 0;
	rbcfp_parser dut (.mclk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.sym_in, .want_value, .action_out, .list_done, .mb_in_valid,
		.mb_skip_bit, .mb_out, .short_term_limit);
	rbcfp_encoder_model enc (.mclk, .sym(sym_in));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// keeps the latest action, since each one stands a single cycle
	always @(posedge mclk) begin
		if (action_out.valid) begin
			last <= action_out;
			acts <= acts + 1;
		end
		// symbol kind against what the parser asks for
		if (sym_in.valid && sym_in.is_value !== want_value)
			odd <= odd + 1;
		ends <= ends + list_done;
	end
	task automatic chk(input string s, input logic [31:0] e, g);
		samples_checked++;
		if (e !== g) begin
			$display("wrong value %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// waits for a fresh action; the field checked depends on its kind
	task automatic act(input logic [2:0] k, input logic [15:0] f);
		int n;
		n = 0;
		while (acts == seen && n < 40) begin
			@(negedge mclk);
			n++;
		end
		chk("action seen", 32'h1, {31'h0, acts != seen});
		seen = acts;
		chk("action kind", {29'h0, k}, {29'h0, last.kind});
		if (k[2:1] == 2'h0)
			chk("action pic", {16'h0, f}, {22'h0, last.pic});
		else if (k[2:1] == 2'h2)
			chk("action area", {16'h0, f}, {16'h0, last.subpic});
		else if (k != 3'h7)
			chk("action index", {16'h0, f}, {16'h0, last.index});
	endtask
	task automatic t_regs;
		bus(1'b0, 8'h0C, 32'h0);
		chk("max index reset", 32'h0, {16'h0, rd[31:16]});
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("response", 32'h0, {31'h0, hresp});
		bus(1'b1, 8'h00, 32'h0001_0003);
	endtask
	task automatic t_cmds;
		enc.bits(16'h3, 3);
		enc.val(enc.diff(3, 1022));
		enc.idle;
		act(3'h0, 16'h3FE);
		enc.bits(16'h3, 3);
		enc.val(16'h0);
		enc.idle;
		act(3'h1, 16'h3);
		enc.bits(16'h4, 4);
		enc.val(16'h2);
		enc.idle;
		act(3'h2, 16'h2);
		enc.bits(16'h5, 4);
		enc.val(16'h2);
		enc.val(16'h4);
		enc.idle;
		act(3'h3, 16'h4);
		enc.bits(16'h6, 5);
		enc.val(16'h3);
		enc.idle;
		act(3'h6, 16'h3);
	endtask
	// 176x144 picture cut into 80x64 areas: 3 across, 3 down; second call cuts it into one 176x144 area
	task automatic t_geom(input logic [15:0] w, h, c);
		enc.bits(16'h7, 5);
		enc.bits(w, 7);
		enc.bits(h, 7);
		enc.val(c);
		enc.bits(16'h1, 1);
		enc.idle;
		act(3'h7, 16'h0);
	endtask
	task automatic t_map;
		bus(1'b0, 8'h08, 32'h0);
		chk("geometry", 32'h0009_0404, rd);
		bus(1'b0, 8'h0C, 32'h0);
		chk("capacity", 32'h0003_0006, rd);
		enc.bits(16'h4, 5);
		enc.val(16'h2);
		enc.map(16'h1, 16'h0, 9);
		enc.idle;
		act(3'h4, 16'h8);
		enc.bits(16'h5, 5);
		enc.val(16'h2);
		enc.map(16'h100, 16'h0, 9);
		enc.bits(16'h1, 1);
		enc.idle;
		act(3'h5, 16'h0);
	endtask
	task automatic mb(input logic v, s);
		@(posedge mclk);
		mb_in_valid <= v;
		mb_skip_bit <= s;
	endtask
	task automatic t_mb;
		mb(1'b1, 1'b1);
		mb(1'b1, 1'b0);
		@(negedge mclk);
		chk("skipped mb", 32'h7E, {25'h0, mb_out});
		mb(1'b0, 1'b0);
		@(negedge mclk);
		chk("coded mb", 32'h41, {25'h0, mb_out});
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{hsel, hwrite, mb_in_valid, mb_skip_bit, arst_n} = 5'h0;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		t_regs;
		t_cmds;
		t_geom(16'h4, 16'h4, 16'h5);
		t_map;
		t_mb;
		t_geom(16'hA, 16'h9, 16'h3);
		bus(1'b0, 8'h18, 32'h0);
		chk("limit", 32'h4, {16'h0, short_term_limit});
		enc.bits(16'h5, 4);
		enc.val(16'h1);
		enc.val(16'h1);
		enc.bits(16'h1, 1);
		enc.idle;
		act(3'h3, 16'h1);
		bus(1'b0, 8'h18, 32'h0);
		chk("limit", 32'h0001_0003, rd);
		chk("symbol kind", 32'h0, odd);
		chk("list ends", 32'h2, ends);
		end_of_test;
	end
	// cuts a hang short
	initial begin
		#20000;
		fail_count++;
		end_of_test;
	end
endmodule
